// ---- hw/kc_kern_if.sv ----
`timescale 1ns/1ps
interface kc_kern_if;
   import kc_pkg::*;
   logic                        wrEn;
   logic                        wrBank;
   logic [IDX_W-1:0]            wrIdx;
   logic [DATA_W-1:0]           wrData;
   logic                        selBank;
   logic [TAPS-1:0][DATA_W-1:0] coef;
   modport ctl   (output wrEn, wrBank, wrIdx, wrData, selBank, input coef);
   modport store (input wrEn, wrBank, wrIdx, wrData, selBank, output coef);
endinterface

// ---- hw/kc_kernel_convolver.sv ----
// Operation
// - Pause is sampled each clock edge; the next cycle the pixel datapath stops.
// - While paused, pixel inputs are ignored; output and state are kept.
// - Frame reset clears only the pause flag and the datapath registers; banks, setup, bank select and load pointers are kept.
// - The frame reset state lasts while the input stays high, clock or not.
// - Frame reset is taken asynchronously at any moment.
// - Two-dimensional output is nine coefficient times 3x3 neighbourhood products summed.
// - One result per pixel continues until frame end, then next frame restarts.
// - Frame reset clears the product stage and the filtered output register.
// - Switching the active bank does not stall the datapath.
// - With mode bit clear, nine successive samples form a 9-tap filter.
// - One-dimensional mode takes samples only from the first row bus.
// - One pixel is accepted on every clock cycle in which the datapath is not held.
// - Setup bit 0 selects signed format, bit 1 selects two-dimensional mode.
// - Setup bits 3:2 pick rounding: none, upper 16 bits, upper 8 bits.
// - Address 2,3 load banks, 4 setup, 5,6 select bank, others nothing.
// - Pin configuration data is captured on the rising edge of the load strobe.
`timescale 1ns/1ps
module kc_kernel_convolver
   import kc_pkg::*;
(
   input  wire logic              sys_clk,       // System clock, 20 MHz
   input  wire logic              reset,         // Sync reset, active high
   input  wire logic              frameReset,    // Async datapath clear, high
   input  wire logic              pause,         // Hold request, sys_clk domain
   input  wire logic [DATA_W-1:0] rowInFirst,    // Newest row pixels
   input  wire logic [DATA_W-1:0] rowInSecond,   // One line delayed
   input  wire logic [DATA_W-1:0] rowInThird,    // Two lines delayed
   output logic      [OUT_W-1:0]  filteredOut,   // Filtered result
   input  wire logic [DATA_W-1:0] coefBus,       // Configuration data pins
   input  wire logic [2:0]        cfgAddr,       // Configuration address pins
   input  wire logic              loadStrobe_n,  // Load strobe, active low
   input  wire logic [3:0]        s_axi_awaddr,  // Write address
   input  wire logic              s_axi_awvalid, // Write address valid
   output logic                   s_axi_awready, // Write address ready
   input  wire logic [31:0]       s_axi_wdata,   // Write data
   input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
   input  wire logic              s_axi_wvalid,  // Write data valid
   output logic                   s_axi_wready,  // Write data ready
   output logic      [1:0]        s_axi_bresp,   // Write response
   output logic                   s_axi_bvalid,  // Write response valid
   input  wire logic              s_axi_bready,  // Write response ready
   input  wire logic [3:0]        s_axi_araddr,  // Read address
   input  wire logic              s_axi_arvalid, // Read address valid
   output logic                   s_axi_arready, // Read address ready
   output logic      [31:0]       s_axi_rdata,   // Read data
   output logic      [1:0]        s_axi_rresp,   // Read response
   output logic                   s_axi_rvalid,  // Read data valid
   input  wire logic              s_axi_rready   // Read data ready
);
   kc_kern_if kern ();

   logic                           hold_ff;
   logic [3:0]                     setupWord_ff;
   logic                           activeBank_ff;
   logic [IDX_W-1:0]               idx0_ff;
   logic [IDX_W-1:0]               idx1_ff;
   logic                           ldMeta_ff;
   logic                           ldSync_ff;
   logic                           ldPrev_ff;
   logic [10:0]                    cfgMeta_ff;
   logic [10:0]                    cfgSync_ff;
   logic                           pinEvt;
   logic                           busEvt;
   logic                           cfgEvt;
   logic [2:0]                     evtAddr;
   logic [DATA_W-1:0]              evtData;
   logic                           mode2d;
   logic                           fmtSigned;
   logic [1:0]                     rndMode;
   logic [TAPS-1:0][DATA_W-1:0]    tap_ff;
   logic [TAPS-1:0][DATA_W-1:0]    nxt_tap;
   logic [2:0][DATA_W-1:0]         rowBus;
   logic [TAPS-1:0][PROD_W-1:0]    prod_ff;
   logic [TAPS-1:0][PROD_W-1:0]    nxt_prod;
   logic [OUT_W-1:0]               sumAll;
   logic [OUT_W-1:0]               nxt_out;
   logic [OUT_W-1:0]               filteredOut_ff;
   logic                           awHave_ff;
   logic                           wHave_ff;
   logic [3:0]                     awAddr_ff;
   logic [31:0]                    wData_ff;
   logic [3:0]                     wStrb_ff;
   logic                           bValid_ff;
   logic [1:0]                     bResp_ff;
   logic                           rValid_ff;
   logic [31:0]                    rData_ff;
   logic [1:0]                     rResp_ff;

   function automatic logic signed [DATA_W:0] extend(input logic [DATA_W-1:0] v,
                                                    input logic            tc);
      extend = {tc & v[DATA_W-1], v};
   endfunction

   assign mode2d    = setupWord_ff[SET_MODE_BIT];
   assign fmtSigned = setupWord_ff[SET_FMT_BIT];
   assign rndMode   = setupWord_ff[SET_RND_LO +: 2];

   // *****************************************
   // Pause sampling
   // *****************************************
   always_ff @(posedge sys_clk or posedge frameReset) begin
      if (frameReset) begin
         hold_ff <= 1'b0;
      end else if (reset) begin
         hold_ff <= 1'b0;
      end else begin
         hold_ff <= pause;
      end
   end

   // *****************************************
   // Configuration pins
   // *****************************************
   // Strobe and address/data are all two-stage synchronised, so they
   // arrive together; data must stay put one clock after the strobe rises.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ldMeta_ff  <= 1'b1;
         ldSync_ff  <= 1'b1;
         ldPrev_ff  <= 1'b1;
         cfgMeta_ff <= '0;
         cfgSync_ff <= '0;
      end else begin
         ldMeta_ff  <= loadStrobe_n;
         ldSync_ff  <= ldMeta_ff;
         ldPrev_ff  <= ldSync_ff;
         cfgMeta_ff <= {cfgAddr, coefBus};
         cfgSync_ff <= cfgMeta_ff;
      end
   end

   assign pinEvt  = ldSync_ff & ~ldPrev_ff;
   assign busEvt  = awHave_ff & wHave_ff & ~bValid_ff & ~pinEvt &
                    (awAddr_ff == OFS_CFG_LOAD) & (&wStrb_ff[1:0]);
   assign cfgEvt  = pinEvt | busEvt;
   assign evtAddr = pinEvt ? cfgSync_ff[10:8] : wData_ff[CFG_ADR_LO +: 3];
   assign evtData = pinEvt ? cfgSync_ff[7:0] : wData_ff[7:0];

   // *****************************************
   // Setup word and bank select
   // *****************************************
   // Only the system reset touches these; frame reset leaves them alone.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         setupWord_ff <= SETUP_RST;
      end else if (cfgEvt && evtAddr == ADR_LOAD_SETUP) begin
         setupWord_ff <= evtData[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         activeBank_ff <= 1'b0;
      end else if (cfgEvt && evtAddr == ADR_SEL_BANK0) begin
         activeBank_ff <= 1'b0;
      end else if (cfgEvt && evtAddr == ADR_SEL_BANK1) begin
         activeBank_ff <= 1'b1;
      end
   end

   // Coefficient pointers run A to I and wrap; a setup load restarts them.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         idx0_ff <= '0;
         idx1_ff <= '0;
      end else if (cfgEvt && evtAddr == ADR_LOAD_SETUP) begin
         idx0_ff <= '0;
         idx1_ff <= '0;
      end else if (cfgEvt && evtAddr == ADR_LOAD_BANK0) begin
         idx0_ff <= (idx0_ff == LAST_IDX) ? '0 : idx0_ff + 4'h1;
      end else if (cfgEvt && evtAddr == ADR_LOAD_BANK1) begin
         idx1_ff <= (idx1_ff == LAST_IDX) ? '0 : idx1_ff + 4'h1;
      end
   end

   assign kern.wrEn    = cfgEvt &&
                         (evtAddr == ADR_LOAD_BANK0 || evtAddr == ADR_LOAD_BANK1);
   assign kern.wrBank  = evtAddr[0];
   assign kern.wrIdx   = evtAddr[0] ? idx1_ff : idx0_ff;
   assign kern.wrData  = evtData;
   assign kern.selBank = activeBank_ff;

   kc_kernel_store u_store (
      .sys_clk (sys_clk),
      .reset   (reset),
      .kern    (kern)
   );

   // *****************************************
   // Pixel window
   // *****************************************
   // Tap 3r+c: row r (0 oldest line), column c (2 newest pixel)
   assign rowBus = {rowInFirst, rowInSecond, rowInThird};

   for (genvar j = 0; j < TAPS; j++) begin : g_tap
      if (j == TAPS - 1) begin : g_head
         assign nxt_tap[j] = rowInFirst;
      end else if (j % 3 == 2) begin : g_row
         assign nxt_tap[j] = mode2d ? rowBus[j/3] : tap_ff[j+1];
      end else begin : g_shift
         assign nxt_tap[j] = tap_ff[j+1];
      end
      assign nxt_prod[j] = PROD_W'(extend(kern.coef[j], fmtSigned) *
                                  extend(tap_ff[j], fmtSigned));
   end

   always_ff @(posedge sys_clk or posedge frameReset) begin
      if (frameReset) begin
         tap_ff <= '0;
      end else if (reset) begin
         tap_ff <= '0;
      end else if (!hold_ff) begin
         tap_ff <= nxt_tap;
      end
   end

   // *****************************************
   // Multiplier stage and adder
   // *****************************************
   always_ff @(posedge sys_clk or posedge frameReset) begin
      if (frameReset) begin
         prod_ff <= '0;
      end else if (reset) begin
         prod_ff <= '0;
      end else if (!hold_ff) begin
         prod_ff <= nxt_prod;
      end
   end

   // Twenty bits hold nine full-scale products, so no overflow either way
   always_comb begin
      sumAll = '0;
      for (int k = 0; k < TAPS; k++) begin
         sumAll = sumAll + {{(OUT_W-PROD_W){prod_ff[k][PROD_W-1] & fmtSigned}},
                            prod_ff[k]};
      end
   end

   // Invalid rounding code passes the full result through
   always_comb begin
      unique case (rndMode)
         RND_16:  nxt_out = (sumAll + RND16_HALF) & RND16_MASK;
         RND_8:   nxt_out = (sumAll + RND8_HALF) & RND8_MASK;
         default: nxt_out = sumAll;
      endcase
   end

   always_ff @(posedge sys_clk or posedge frameReset) begin
      if (frameReset) begin
         filteredOut_ff <= '0;
      end else if (reset) begin
         filteredOut_ff <= '0;
      end else if (!hold_ff) begin
         filteredOut_ff <= nxt_out;
      end
   end

   assign filteredOut = filteredOut_ff;

   // *****************************************
   // AXI4-Lite slave
   // *****************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         awHave_ff <= 1'b0;
         awAddr_ff <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHave_ff <= 1'b1;
         awAddr_ff <= s_axi_awaddr;
      end else if (awHave_ff && wHave_ff && !bValid_ff && !pinEvt) begin
         awHave_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wHave_ff <= 1'b0;
         wData_ff <= '0;
         wStrb_ff <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHave_ff <= 1'b1;
         wData_ff <= s_axi_wdata;
         wStrb_ff <= s_axi_wstrb;
      end else if (awHave_ff && wHave_ff && !bValid_ff && !pinEvt) begin
         wHave_ff <= 1'b0;
      end
   end

   // A pin load in the same cycle delays the bus write by one clock
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bValid_ff <= 1'b0;
         bResp_ff  <= RESP_OKAY;
      end else if (awHave_ff && wHave_ff && !bValid_ff && !pinEvt) begin
         bValid_ff <= 1'b1;
         bResp_ff  <= (awAddr_ff == OFS_CFG_LOAD) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rValid_ff <= 1'b0;
         rData_ff  <= '0;
         rResp_ff  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_ff <= 1'b1;
         rResp_ff  <= RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_STATUS: begin
               rData_ff <= {15'h0000, hold_ff, idx1_ff, idx0_ff, 3'h0,
                            activeBank_ff, setupWord_ff};
            end
            OFS_FILTERED: begin
               rData_ff <= {12'h000, filteredOut_ff};
            end
            default: begin
               rData_ff <= '0;
               rResp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   assign s_axi_awready = !awHave_ff && !bValid_ff;
   assign s_axi_wready  = !wHave_ff && !bValid_ff;
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;
   assign s_axi_arready = !rValid_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;

   // *****************************************
   // Checks
   // *****************************************
   property p_hold_out;
      @(posedge sys_clk) disable iff (reset || frameReset)
      pause |=> ##1 $stable(filteredOut_ff);
   endproperty
   a_hold_out: assert property (p_hold_out)
      else $error("output moved in the cycle after pause");

   property p_hold_taps;
      @(posedge sys_clk) disable iff (reset || frameReset)
      hold_ff |=> $stable(tap_ff) && $stable(prod_ff);
   endproperty
   a_hold_taps: assert property (p_hold_taps)
      else $error("datapath state changed while held");

   property p_frame_clear;
      @(posedge sys_clk) disable iff (reset)
      frameReset |-> filteredOut_ff == '0 && prod_ff == '0 && tap_ff == '0;
   endproperty
   a_frame_clear: assert property (p_frame_clear)
      else $error("datapath not clear during frame reset");

   property p_frame_keep;
      @(posedge sys_clk) disable iff (reset)
      frameReset && !cfgEvt |=> $stable(setupWord_ff) && $stable(activeBank_ff);
   endproperty
   a_frame_keep: assert property (p_frame_keep)
      else $error("frame reset disturbed the configuration");

   property p_one_dim;
      @(posedge sys_clk) disable iff (reset || frameReset)
      !mode2d && !hold_ff ##1 !mode2d && !hold_ff |=> tap_ff[TAPS-2] == $past(rowInFirst, 2);
   endproperty
   a_one_dim: assert property (p_one_dim)
      else $error("sample not two taps down the delay line");

   property p_sel_bank;
      @(posedge sys_clk) disable iff (reset)
      cfgEvt && evtAddr == ADR_SEL_BANK1 |=> activeBank_ff ##1 kern.coef == $past(u_store.bank1_ff);
   endproperty
   a_sel_bank: assert property (p_sel_bank)
      else $error("bank 1 select not applied");

   property p_round8;
      @(posedge sys_clk) disable iff (reset || frameReset)
      !hold_ff && rndMode == RND_8 |=> filteredOut_ff[11:0] == 12'h000;
   endproperty
   a_round8: assert property (p_round8)
      else $error("low bits not cleared by 8-bit rounding");

   property p_pin_setup;
      @(posedge sys_clk) disable iff (reset)
      pinEvt && cfgSync_ff[10:8] == ADR_LOAD_SETUP |=> setupWord_ff == $past(cfgSync_ff[3:0]);
   endproperty
   a_pin_setup: assert property (p_pin_setup)
      else $error("setup word not taken on strobe release");

   property p_reset_bank;
      @(posedge sys_clk) $fell(reset) |-> !activeBank_ff;
   endproperty
   a_reset_bank: assert property (p_reset_bank)
      else $error("bank 0 not active after reset");
endmodule

// ---- hw/kc_kernel_store.sv ----
`timescale 1ns/1ps
module kc_kernel_store
   import kc_pkg::*;
(
   input  wire logic sys_clk, // System clock
   input  wire logic reset,   // Sync reset, active high
   kc_kern_if.store  kern     // Write port and active coefficients
);
   logic [TAPS-1:0][DATA_W-1:0] bank0_ff;
   logic [TAPS-1:0][DATA_W-1:0] bank1_ff;
   logic [TAPS-1:0][DATA_W-1:0] coef_ff;

   // ***************************************
   // Banks, untouched by frame reset
   // ***************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bank0_ff <= '0;
         bank1_ff <= '0;
      end else if (kern.wrEn && kern.wrIdx <= LAST_IDX) begin
         if (kern.wrBank) begin
            bank1_ff[kern.wrIdx] <= kern.wrData;
         end else begin
            bank0_ff[kern.wrIdx] <= kern.wrData;
         end
      end
   end

   // Exactly one bank feeds the multipliers; read is registered
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         coef_ff <= '0;
      end else begin
         coef_ff <= kern.selBank ? bank1_ff : bank0_ff;
      end
   end

   assign kern.coef = coef_ff;

   property p_bank_route;
      @(posedge sys_clk) disable iff (reset)
      ##1 1'b1 |-> coef_ff == ($past(kern.selBank) ? $past(bank1_ff) : $past(bank0_ff));
   endproperty
   a_bank_route: assert property (p_bank_route)
      else $error("active coefficients not from the selected bank");
endmodule

// ---- hw/kc_pkg.sv ----
package kc_pkg;
   localparam int DATA_W = 8;
   localparam int OUT_W  = 20;
   localparam int PROD_W = 18;
   localparam int TAPS   = 9;
   localparam int IDX_W  = 4;
   localparam logic [IDX_W-1:0] LAST_IDX = 4'h8;

   // Configuration address codes
   localparam logic [2:0] ADR_LOAD_BANK0 = 3'h2;
   localparam logic [2:0] ADR_LOAD_BANK1 = 3'h3;
   localparam logic [2:0] ADR_LOAD_SETUP = 3'h4;
   localparam logic [2:0] ADR_SEL_BANK0  = 3'h5;
   localparam logic [2:0] ADR_SEL_BANK1  = 3'h6;

   // Setup word fields
   localparam int SET_FMT_BIT  = 0;
   localparam int SET_MODE_BIT = 1;
   localparam int SET_RND_LO   = 2;
   localparam logic [3:0] SETUP_RST = 4'h0;
   localparam logic [1:0] RND_NONE  = 2'h0;
   localparam logic [1:0] RND_16    = 2'h1;
   localparam logic [1:0] RND_8     = 2'h2;
   localparam logic [OUT_W-1:0] RND16_HALF = 20'h00008;
   localparam logic [OUT_W-1:0] RND16_MASK = 20'hFFFF0;
   localparam logic [OUT_W-1:0] RND8_HALF  = 20'h00800;
   localparam logic [OUT_W-1:0] RND8_MASK  = 20'hFF000;

   // Bus map (byte addresses)
   localparam logic [3:0] OFS_CFG_LOAD = 4'h0;
   localparam logic [3:0] OFS_STATUS   = 4'h4;
   localparam logic [3:0] OFS_FILTERED = 4'h8;
   localparam int CFG_ADR_LO = 8;
   localparam int ST_BANK    = 4;
   localparam int ST_IDX0_LO = 8;
   localparam int ST_IDX1_LO = 12;
   localparam int ST_HOLD    = 16;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- sim/kc_kernel_convolver_bench.sv ----
`timescale 1ns/1ps
module kc_kernel_convolver_bench
   import kc_pkg::*;
;
   logic        sys_clk, reset, frameReset, pause, pauseQ, ldN;
   logic [7:0]  rowA, rowB, rowC, coefBus;
   logic [2:0]  cfgAddr;
   logic [19:0] filt;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, resp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          mismatches, cmp_count;
   logic [7:0]  st [5] = '{8'h02, 8'h06, 8'h0A, 8'h0E, 8'h03};
   logic [19:0] ex [5] = '{20'h011EE, 20'h011F0, 20'h01000, 20'h011EE, 20'hFFFEE};

   initial sys_clk = 1'b0;
   always #25 sys_clk = ~sys_clk;

   // The core stalls one edge after it samples pause; the buffers must match it
   always_ff @(posedge sys_clk) begin
      pauseQ <= pause;
   end

   kc_row_delay u_line1 (.sys_clk(sys_clk), .shiftEn(!pauseQ), .din(rowA), .dout(rowB));
   kc_row_delay u_line2 (.sys_clk(sys_clk), .shiftEn(!pauseQ), .din(rowB), .dout(rowC));
   kc_kernel_convolver u_dut (
      .sys_clk(sys_clk), .reset(reset), .frameReset(frameReset), .pause(pause),
      .rowInFirst(rowA), .rowInSecond(rowB), .rowInThird(rowC), .filteredOut(filt),
      .coefBus(coefBus), .cfgAddr(cfgAddr), .loadStrobe_n(ldN),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Both directions share one handshake loop; ready is looked at mid-cycle
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int   n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= wr;
      wvalid <= wr;
      arvalid <= !wr;
      bready <= wr;
      rready <= !wr;
      while (!tb && n < 40) begin
         @(negedge sys_clk);
         ta = awvalid && awready || arvalid && arready;
         tw = wvalid && wready;
         tb = bvalid && bready || rvalid && rready;
         resp = wr ? bresp : rresp;
         rd = rdata;
         @(posedge sys_clk);
         if (ta) awvalid <= 1'b0;
         if (ta) arvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      // Let an edge pass so a following call never re-raises ready in this step
      tick(1);
      if (!tb) begin
         mismatches++;
         finish_test();
      end
   endtask

   task automatic pin(input logic [2:0] a, input logic [7:0] d);
      cfgAddr <= a;
      coefBus <= d;
      ldN <= 1'b0;
      tick(2);
      ldN <= 1'b1;
      tick(5);
   endtask

   task automatic stream(input logic [7:0] v, input logic [19:0] e);
      rowA <= v;
      tick(16);
      @(negedge sys_clk);
      chk(filt, e);
      @(posedge sys_clk);
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_config;
      bus(0, OFS_STATUS, 0);
      chk(rd, 0);
      bus(0, 4'hC, 0);
      chk(resp, RESP_SLVERR);
      pin(ADR_LOAD_SETUP, 8'h00);
      for (int k = 0; k < 9; k++) pin(ADR_LOAD_BANK0, 8'(k + 1));
      for (int k = 0; k < 9; k++) bus(1, OFS_CFG_LOAD, {21'h0, ADR_LOAD_BANK1, 8'h02});
      chk(resp, RESP_OKAY);
      pin(3'h0, 8'h55);
      pin(3'h1, 8'h55);
      pin(3'h7, 8'h55);
      bus(0, OFS_STATUS, 0);
      chk(rd, 0);
      stream(8'h03, 20'd135);
   endtask

   task automatic t_hold_frame;
      pause <= 1'b1;
      tick(1);
      rowA <= 8'h05;
      tick(4);
      @(negedge sys_clk);
      chk(filt, 20'd135);
      @(posedge sys_clk);
      frameReset <= 1'b1;
      @(negedge sys_clk);
      chk(filt, 0);
      tick(3);
      @(negedge sys_clk);
      chk(filt, 0);
      @(posedge sys_clk);
      frameReset <= 1'b0;
      pause <= 1'b0;
      stream(8'h05, 20'd225);
   endtask

   task automatic t_bank_modes;
      pin(ADR_SEL_BANK1, 8'h00);
      stream(8'h03, 20'd54);
      for (int i = 0; i < 5; i++) begin
         pin(ADR_LOAD_SETUP, st[i]);
         stream(8'hFF, ex[i]);
      end
      bus(0, OFS_FILTERED, 0);
      chk(rd, 32'h000FFFEE);
      pin(ADR_SEL_BANK0, 8'h00);
      stream(8'hFF, 20'hFFFD3);
   endtask

   // Single pixel through the 1-D line: bank 0 holds 1..9, so I comes out first
   task automatic t_impulse;
      rowA <= 8'h00;
      pin(ADR_LOAD_SETUP, 8'h00);
      tick(12);
      rowA <= 8'h01;
      tick(1);
      rowA <= 8'h00;
      tick(2);
      for (int k = 9; k >= 0; k--) begin
         @(negedge sys_clk);
         chk(filt, 20'(k));
         @(posedge sys_clk);
      end
   endtask

   initial begin
      mismatches = 0;
      cmp_count = 0;
      reset = 1'b1;
      frameReset = 1'b0;
      pause = 1'b0;
      ldN = 1'b1;
      rowA = 8'h00;
      coefBus = 8'h00;
      cfgAddr = 3'h7;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      tick(10);
      reset <= 1'b0;
      tick(1);
      t_config();
      t_hold_frame();
      t_bank_modes();
      t_impulse();
      finish_test();
   end

   initial begin
      tick(20000);
      mismatches++;
      finish_test();
   end
endmodule

// ---- sim/kc_row_delay.sv ----
`timescale 1ns/1ps
// ************************************************
// Line buffer model, one row of delay
// ************************************************
module kc_row_delay #(
   parameter int LINE = 4
) (
   input  wire logic       sys_clk, // System clock
   input  wire logic       shiftEn, // Advance one pixel
   input  wire logic [7:0] din,     // Incoming pixels
   output logic      [7:0] dout     // Pixels one row later
);
   logic [LINE-1:0][7:0] line_ff;

   // Stalls with the core so rows stay aligned
   always_ff @(posedge sys_clk) begin
      if (shiftEn) begin
         line_ff <= {line_ff[LINE-2:0], din};
      end
   end
   assign dout = line_ff[LINE-1];
endmodule
